// ==== src/spi_host_pkg.sv ====
// shared constants for the host serial port and its helpers
package spi_host_pkg;
    // byte framing on the serial link
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BIT_CNT_W-1:0] BIT_STEP = 3'h1;
    // command byte bit that selects a read
    localparam int CMD_RD_POS = 7;
    // byte index counters inside one frame
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_ZERO = 8'h00;
    localparam logic [IDX_W-1:0] IDX_ONE = 8'h01;
    localparam logic [IDX_W-1:0] IDX_MAX = 8'hff;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    // synchroniser lanes into the system clock
    localparam int SYNC_W = 3;
    localparam int SYNC_CS = 0;
    localparam int SYNC_RX = 1;
    localparam int SYNC_RD = 2;
    localparam logic CS_IDLE = 1'b1;
    // serial clock ceiling against the system clock
    localparam int SYS_CLK_KHZ = 40000;
    localparam int SCK_MAX_KHZ = 10000;
    localparam int SYS_PER_SCK = SYS_CLK_KHZ / SCK_MAX_KHZ;
endpackage : spi_host_pkg

// ==== src/sync_agree.sv ====
// three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module sync_agree
    import spi_host_pkg::*;
#(
    parameter int W = SYNC_W,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;
    logic [W-1:0] agree;

    // stage one feeds stage two only; the filter looks at two and three
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            assign agree[i] = (st_r.s2[i] == st_r.s3[i]);
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = (agree & st_r.s3) | (~agree & st_r.q);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule : sync_agree

// ==== src/so_driver.sv ====
// serial output shifter, launched on falling clock edges
`timescale 1ns/1ps
module so_driver
    import spi_host_pkg::*;
(
    input wire logic sck,
    input wire logic cs_n,
    input wire logic load,
    input wire logic [BYTE_W-1:0] load_byte,
    output logic so,
    output logic so_oe_n
);
    typedef struct packed {
        logic [BYTE_W-1:0] shift;
        logic drive;
    } drv_s;

    drv_s st_r;
    drv_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (load)
        begin
            st_nxt.shift = load_byte;
            st_nxt.drive = 1'b1;
        end
        else
        begin
            st_nxt.shift = {st_r.shift[BYTE_W-2:0], 1'b0};
        end
    end

    // select high releases the pin at once, without waiting for a clock
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign so = st_r.shift[BYTE_W-1];
    assign so_oe_n = ~st_r.drive;
endmodule : so_driver

// ==== src/spi_slave_host_port.sv ====
// host serial port: mode 0 slave framing, byte delivery and read return
// Notes on behaviour
// - the port is a slave; clock and select are only ever inputs.
// - mode 0: input sampled on rising clock, output changes on falling clock.
// - data moves in 8-bit bytes, most significant bit first.
// - select rising ends the transfer and restarts the port state.
// - a byte cut short by select rising is discarded; frame_partial flags it.
// - serial output floats except while read data is shifting out.
// - serial input is ignored while read data is shifting out.
// - every operation opens with an 8-bit command byte after select falls.
// - a data byte follows the command byte at once.
// - further data bytes before select rises make a multi-byte access.
// - undefined commands must not be used; their read data is meaningless.
`timescale 1ns/1ps
module spi_slave_host_port
    import spi_host_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    output logic cmd_valid,
    output logic [BYTE_W-1:0] cmd_byte,
    output logic cmd_is_read,
    output logic wr_valid,
    output logic [BYTE_W-1:0] wr_byte,
    output logic [IDX_W-1:0] wr_index,
    input wire logic rd_load,
    input wire logic [BYTE_W-1:0] rd_data,
    output logic rd_next,
    output logic [IDX_W-1:0] rd_index,
    output logic rd_stale,
    output logic frame_active,
    output logic frame_done,
    output logic frame_partial,
    output logic frame_no_data,
    output logic [IDX_W-1:0] frame_bytes
);
    // link state that lives only for one select frame
    typedef struct packed {
        logic [BIT_CNT_W-1:0] cnt;
        logic [BYTE_W-2:0] shift;
        logic in_data;
        logic rd_phase;
        logic started;
    } link_s;

    // link state that must outlive the frame so the system side can read it
    typedef struct packed {
        logic rx_tgl;
        logic rx_cmd;
        logic [BYTE_W-1:0] rx_byte;
        logic rd_tgl;
        logic fr_tgl;
        logic [BIT_CNT_W-1:0] bits;
    } evt_s;

    typedef struct packed {
        logic rx_seen;
        logic rd_seen;
        logic cs_seen;
        logic fr_seen;
        // frame tally copied each cycle; only read once select has settled high
        logic fr_cap;
        logic [BIT_CNT_W-1:0] bits_cap;
        logic cmd_valid;
        logic [BYTE_W-1:0] cmd_byte;
        logic cmd_is_read;
        logic wr_valid;
        logic [BYTE_W-1:0] wr_byte;
        logic [IDX_W-1:0] wr_index;
        logic [IDX_W-1:0] wr_cnt;
        logic rd_next;
        logic [IDX_W-1:0] rd_index;
        logic [IDX_W-1:0] rd_cnt;
        logic [BYTE_W-1:0] rd_hold;
        logic rd_fresh;
        logic rd_stale;
        logic got_cmd;
        logic got_data;
        logic active;
        logic done;
        logic partial;
        logic no_data;
        logic [IDX_W-1:0] byte_cnt;
        logic [IDX_W-1:0] bytes;
    } sys_s;

    link_s lk_r;
    link_s lk_nxt;
    evt_s ev_r;
    evt_s ev_nxt;
    sys_s sy_r;
    sys_s sy_nxt;
    logic [BYTE_W-1:0] rx_full;
    logic [SYNC_W-1:0] sq;
    logic rx_evt;
    logic rd_evt;
    logic cs_fall;
    logic cs_rise;
    logic so_load;

    // ---- link side, rising serial clock ----
    always_comb
    begin
        lk_nxt = lk_r;
        ev_nxt = ev_r;
        rx_full = {lk_r.shift, si};
        lk_nxt.started = 1'b1;
        lk_nxt.cnt = lk_r.cnt + BIT_STEP;
        // bit tally for the frame, so a short tail can be spotted later
        if (!lk_r.started)
        begin
            ev_nxt.fr_tgl = ~ev_r.fr_tgl;
            ev_nxt.bits = BIT_STEP;
        end
        else
        begin
            ev_nxt.bits = ev_r.bits + BIT_STEP;
        end
        // once reading, the rest of the frame is output only
        if (lk_r.rd_phase)
        begin
            // first rising edge after a byte was launched: tell the system side
            if (lk_r.cnt == BIT_FIRST)
            begin
                ev_nxt.rd_tgl = ~ev_r.rd_tgl;
            end
            // input shifter frozen while read data goes out
            lk_nxt.shift = lk_r.shift;
        end
        else
        begin
            lk_nxt.shift = rx_full[BYTE_W-2:0];
            // only a full eighth bit publishes a byte
            if (lk_r.cnt == BIT_LAST)
            begin
                ev_nxt.rx_tgl = ~ev_r.rx_tgl;
                ev_nxt.rx_byte = rx_full;
                ev_nxt.rx_cmd = ~lk_r.in_data;
                lk_nxt.in_data = 1'b1;
                lk_nxt.rd_phase = ~lk_r.in_data & rx_full[CMD_RD_POS];
            end
        end
        // edges while deselected belong to another slave sharing the clock
        if (cs_n)
        begin
            ev_nxt = ev_r;
        end
    end

    // select high is the frame's own end; no clock edge needed to restart
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            lk_r <= '0;
        end
        else
        begin
            lk_r <= lk_nxt;
        end
    end

    // kept across frames; the system side reads it after the toggles settle
    always_ff @(posedge sck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ev_r <= '0;
        end
        else
        begin
            ev_r <= ev_nxt;
        end
    end

    // launch point: falling edge after the command byte, then every eighth
    assign so_load = lk_r.rd_phase && (lk_r.cnt == BIT_FIRST);

    // holding byte crosses unsynchronised: loads must keep clear of launches
    so_driver u_so_driver (
        .sck(sck),
        .cs_n(cs_n),
        .load(so_load),
        .load_byte(sy_r.rd_hold),
        .so(so),
        .so_oe_n(so_oe_n)
    );

    // ---- crossing into the system clock ----
    // select shares the synchroniser so frame edges and byte toggles age alike
    sync_agree #(
        .W(SYNC_W),
        .RST_VAL({1'b0, 1'b0, CS_IDLE})
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({ev_r.rd_tgl, ev_r.rx_tgl, cs_n}),
        .q(sq)
    );

    // toggles turn into one-cycle events against the last seen level
    assign rx_evt = (sq[SYNC_RX] != sy_r.rx_seen);
    assign rd_evt = (sq[SYNC_RD] != sy_r.rd_seen);
    assign cs_fall = sy_r.cs_seen && !sq[SYNC_CS];
    assign cs_rise = !sy_r.cs_seen && sq[SYNC_CS];

    // ---- system side ----
    always_comb
    begin
        sy_nxt = sy_r;
        sy_nxt.cmd_valid = 1'b0;
        sy_nxt.wr_valid = 1'b0;
        sy_nxt.rd_next = 1'b0;
        sy_nxt.rd_stale = 1'b0;
        sy_nxt.done = 1'b0;
        sy_nxt.partial = 1'b0;
        sy_nxt.no_data = 1'b0;
        // the rx, rd and cs seen copies follow the synchroniser every cycle
        sy_nxt.rx_seen = sq[SYNC_RX];
        sy_nxt.rd_seen = sq[SYNC_RD];
        sy_nxt.cs_seen = sq[SYNC_CS];
        sy_nxt.fr_cap = ev_r.fr_tgl;
        sy_nxt.bits_cap = ev_r.bits;
        // counters restart on select falling, so frame_bytes outlives the frame
        if (cs_fall)
        begin
            sy_nxt.active = 1'b1;
            sy_nxt.got_cmd = 1'b0;
            sy_nxt.got_data = 1'b0;
            sy_nxt.wr_cnt = IDX_ZERO;
            sy_nxt.rd_cnt = IDX_ZERO;
            sy_nxt.byte_cnt = IDX_ZERO;
        end
        // byte content is stable for seven more clocks, well past the sync
        if (rx_evt)
        begin
            if (sy_nxt.byte_cnt != IDX_MAX)
            begin
                sy_nxt.byte_cnt = sy_nxt.byte_cnt + IDX_ONE;
            end
            if (ev_r.rx_cmd)
            begin
                sy_nxt.cmd_valid = 1'b1;
                sy_nxt.cmd_byte = ev_r.rx_byte;
                sy_nxt.cmd_is_read = ev_r.rx_byte[CMD_RD_POS];
                sy_nxt.got_cmd = 1'b1;
                sy_nxt.wr_cnt = IDX_ZERO;
                sy_nxt.rd_cnt = IDX_ZERO;
            end
            else
            begin
                sy_nxt.wr_valid = 1'b1;
                sy_nxt.wr_byte = ev_r.rx_byte;
                sy_nxt.wr_index = sy_nxt.wr_cnt;
                sy_nxt.got_data = 1'b1;
                if (sy_nxt.wr_cnt != IDX_MAX)
                begin
                    sy_nxt.wr_cnt = sy_nxt.wr_cnt + IDX_ONE;
                end
            end
        end
        // a byte has been launched into the shifter; the holding byte may be replaced now
        if (rd_evt)
        begin
            sy_nxt.rd_next = 1'b1;
            sy_nxt.rd_index = sy_r.rd_cnt;
            sy_nxt.rd_stale = ~sy_r.rd_fresh;
            sy_nxt.rd_fresh = 1'b0;
            sy_nxt.got_data = 1'b1;
            if (sy_r.byte_cnt != IDX_MAX)
            begin
                sy_nxt.byte_cnt = sy_nxt.byte_cnt + IDX_ONE;
            end
            if (sy_r.rd_cnt != IDX_MAX)
            begin
                sy_nxt.rd_cnt = sy_r.rd_cnt + IDX_ONE;
            end
        end
        // a load in the same cycle as a take counts for the next byte
        if (rd_load)
        begin
            sy_nxt.rd_hold = rd_data;
            sy_nxt.rd_fresh = 1'b1;
        end
        if (cs_rise)
        begin
            sy_nxt.active = 1'b0;
            sy_nxt.done = 1'b1;
            sy_nxt.bytes = sy_nxt.byte_cnt;
            // a read byte counts when it starts, so a cut one is taken back
            if ((sy_r.rd_cnt != IDX_ZERO) && (sy_r.bits_cap != BIT_FIRST))
            begin
                sy_nxt.bytes = sy_nxt.byte_cnt - IDX_ONE;
            end
            // a frame with no clock edges leaves the tally untouched
            sy_nxt.partial = (sy_r.fr_cap != sy_r.fr_seen)
                && (sy_r.bits_cap != BIT_FIRST);
            sy_nxt.fr_seen = sy_r.fr_cap;
            sy_nxt.no_data = sy_nxt.got_cmd && !sy_nxt.got_data;
        end
    end

    // holding byte resets to zero; an unloaded first read shifts out zeros
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sy_r <= '0;
            sy_r.cs_seen <= CS_IDLE;
            sy_r.rd_hold <= BYTE_RST;
        end
        else
        begin
            sy_r <= sy_nxt;
        end
    end

    // every output is a flop, so the system side sees no glitches
    assign cmd_valid = sy_r.cmd_valid;
    assign cmd_byte = sy_r.cmd_byte;
    assign cmd_is_read = sy_r.cmd_is_read;
    assign wr_valid = sy_r.wr_valid;
    assign wr_byte = sy_r.wr_byte;
    assign wr_index = sy_r.wr_index;
    assign rd_next = sy_r.rd_next;
    assign rd_index = sy_r.rd_index;
    assign rd_stale = sy_r.rd_stale;
    assign frame_active = sy_r.active;
    assign frame_done = sy_r.done;
    assign frame_partial = sy_r.partial;
    assign frame_no_data = sy_r.no_data;
    assign frame_bytes = sy_r.bytes;
endmodule : spi_slave_host_port

// ==== test/spi_port_props.sv ====
// concurrent checks on the host serial port pins and event outputs
`timescale 1ns/1ps
module spi_port_props
    import spi_host_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_oe_n,
    input wire logic cmd_valid,
    input wire logic [BYTE_W-1:0] cmd_byte,
    input wire logic cmd_is_read,
    input wire logic wr_valid,
    input wire logic frame_done,
    input wire logic frame_partial,
    input wire logic frame_no_data
);
    logic [5:0] rise_r;
    logic [7:0] cmd_r;
    // cleared by select high, like the port's own frame state
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            rise_r <= 6'h00;
            cmd_r <= 8'h00;
        end
        else
        begin
            rise_r <= (rise_r == 6'h3f) ? rise_r : rise_r + 6'h01;
            cmd_r <= (rise_r < 6'h08) ? {cmd_r[6:0], si} : cmd_r;
        end
    end
    sequence rd_cmd_s;
        rise_r >= 6'h08 && cmd_r[CMD_RD_POS];
    endsequence
    sequence wr_cmd_s;
        rise_r >= 6'h08 && !cmd_r[CMD_RD_POS];
    endsequence
    chk_read_drive: assert property (@(posedge sck) disable iff (cs_n)
        rd_cmd_s |-> !so_oe_n) else $error("read data not driven");
    chk_cmd_float: assert property (@(posedge sck) disable iff (cs_n)
        rise_r < 6'h08 |-> so_oe_n) else $error("output driven during command");
    chk_write_float: assert property (@(posedge sck) disable iff (cs_n)
        wr_cmd_s |-> so_oe_n) else $error("output driven during write");
    chk_oe_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cs_n |-> so_oe_n) else $error("output driven while deselected");
    chk_cmd_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cmd_valid |=> !cmd_valid) else $error("command pulse too long");
    chk_cmd_read_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cmd_valid |-> cmd_is_read == cmd_byte[CMD_RD_POS]) else $error("read flag wrong");
    chk_read_no_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_valid |-> !cmd_is_read) else $error("input taken during read");
    chk_flags_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
        frame_partial || frame_no_data |-> frame_done) else $error("flag without frame end");
endmodule : spi_port_props

bind spi_slave_host_port spi_port_props spi_port_props_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .so_oe_n(so_oe_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_is_read(cmd_is_read),
    .wr_valid(wr_valid), .frame_done(frame_done), .frame_partial(frame_partial),
    .frame_no_data(frame_no_data));

// ==== test/spi_host_model.sv ====
// host master model: mode 0 frames shifted msb first
`timescale 1ns/1ps
module spi_host_model
(
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    initial
    begin
        // after time zero, so the select edge resets the frame logic
        cs_n <= 1'b1;
        sck <= 1'b0;
        si <= 1'b0;
    end
    // steps of 15 ns never land on a system clock edge; a fast link stresses the crossings
    task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
        output int first_oe);
        first_oe = -1;
        rx = 32'h0000_0000;
        #7 cs_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            si = tx[31-i];
            #15 sck = 1'b1;
            rx = {rx[30:0], so};
            if (so_oe_n === 1'b0 && first_oe < 0)
                first_oe = i;
            #15 sck = 1'b0;
        end
        si = ~si;
        #210 cs_n = 1'b1;
        #210;
    endtask : frame
endmodule : spi_host_model

// ==== test/testbench.sv ====
// self-checking bench for the host serial port
`timescale 1ns/1ps
module testbench;
    import spi_host_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst;
    logic rd_load = 1'b0;
    logic [7:0] rd_data = 8'h00;
    wire logic sck, cs_n, si, so_w;
    logic so, so_oe_n, cmd_valid, cmd_is_read, wr_valid, rd_next, rd_stale;
    logic frame_active, frame_done, frame_partial, frame_no_data;
    logic [7:0] cmd_byte, wr_byte, wr_index, rd_index, frame_bytes;
    int n_errors = 0;
    int checks_done = 0;
    int act_cycles = 0;
    logic [8:0] cq[$];
    logic [15:0] wq[$];
    logic [8:0] rq[$];
    logic [9:0] fq[$];
    logic [31:0] rx;
    int first_oe;
    assign so_w = so_oe_n ? 1'bz : so;
    always #12.5 clk_sys = ~clk_sys;
    spi_slave_host_port spi_slave_host_port_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_is_read(cmd_is_read), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .wr_index(wr_index), .rd_load(rd_load), .rd_data(rd_data),
        .rd_next(rd_next), .rd_index(rd_index), .rd_stale(rd_stale),
        .frame_active(frame_active), .frame_done(frame_done), .frame_partial(frame_partial),
        .frame_no_data(frame_no_data), .frame_bytes(frame_bytes));
    spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so_w),
        .so_oe_n(so_oe_n));
    // sampled mid-cycle so registered outputs have settled
    always @(negedge clk_sys)
    begin
        if (cmd_valid === 1'b1)
            cq.push_back({cmd_is_read, cmd_byte});
        if (wr_valid === 1'b1)
            wq.push_back({wr_index, wr_byte});
        if (rd_next === 1'b1)
            rq.push_back({rd_stale, rd_index});
        if (frame_active === 1'b1)
            act_cycles++;
        if (frame_done === 1'b1)
            fq.push_back({frame_partial, frame_no_data, frame_bytes});
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic run(input logic [31:0] tx, input int nbits, input logic [9:0] fexp);
        cq.delete();
        wq.delete();
        rq.delete();
        fq.delete();
        act_cycles = 0;
        @(posedge clk_sys);
        spi_host_model_inst.frame(tx, nbits, rx, first_oe);
        for (int i = 0; i < 40 && fq.size() == 0; i++)
            @(posedge clk_sys);
        check(fq.size() == 1 && fq[0] === fexp, "frame end flags");
        check(act_cycles > 8 && frame_active === 1'b0, "frame active level");
    endtask : run
    task automatic t_write();
        run({8'h12, 8'ha5, 16'h0000}, 16, {2'b00, 8'h02});
        check(cq.size() == 1 && cq[0] === {1'b0, 8'h12}, "command");
        check(wq.size() == 1 && wq[0] === {8'h00, 8'ha5}, "write byte");
        check(first_oe == -1, "output driven");
    endtask : t_write
    task automatic t_multi();
        run({8'h07, 8'h11, 8'h22, 8'h33}, 32, {2'b00, 8'h04});
        for (int i = 0; i < 3; i++)
            check(wq.size() == 3 && wq[i] === {8'(i), 8'(8'h11 * (i + 1))}, "multi");
    endtask : t_multi
    task automatic t_read();
        @(posedge clk_sys);
        rd_load <= 1'b1;
        rd_data <= 8'hc3;
        @(posedge clk_sys);
        rd_load <= 1'b0;
        run({8'h85, 8'hff, 16'h0000}, 16, {2'b00, 8'h02});
        check(rx[7:0] === 8'hc3, "read data");
        check(first_oe == 8, "drive start");
        check(wq.size() == 0, "input taken in read");
        check(cq.size() == 1 && cq[0] === {1'b1, 8'h85}, "read command");
        check(rq.size() == 1 && rq[0] === {1'b0, 8'h00}, "read index");
        // no reload: the held byte goes out again and is flagged stale
        run({8'h85, 8'h00, 16'h0000}, 16, {2'b00, 8'h02});
        check(rx[7:0] === 8'hc3 && first_oe == 8, "repeat read data");
        check(rq.size() == 1 && rq[0] === {1'b1, 8'h00}, "stale flag");
        run({8'h85, 5'b00000, 19'h0_0000}, 13, {2'b10, 8'h01});
        check(rq.size() == 1 && wq.size() == 0, "cut read");
    endtask : t_read
    task automatic t_partial();
        run({8'h34, 5'b10110, 19'h0_0000}, 13, {2'b11, 8'h01});
        check(cq.size() == 1 && wq.size() == 0, "partial byte used");
        run({8'h56, 8'h0f, 16'h0000}, 16, {2'b00, 8'h02});
        check(cq.size() == 1 && cq[0] === {1'b0, 8'h56}, "restart command");
        check(wq.size() == 1 && wq[0] === {8'h00, 8'h0f}, "restart data");
        run({8'h21, 24'h00_0000}, 8, {2'b01, 8'h01});
        check(wq.size() == 0, "data without byte");
    endtask : t_partial
    initial
    begin
        // a real edge, so the link event flops clear as well
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_write();
        t_multi();
        t_read();
        t_partial();
        stop_test();
    end
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule : testbench
